// file: inc/sfb_pkg.sv
`default_nettype none
package sfb_pkg;
    // Array geometry
    localparam int ADDR_W = 17;
    localparam int DQ_W = 32;
    localparam int LANES = 4;
    localparam int LANE_W = 8;
    localparam int WORD_W = DQ_W + LANES;
    localparam int MEM_WORDS = 131072;
    // Burst counter covers the two low address bits
    localparam int BURST_W = 2;
    // Host command FIFO
    localparam int FIFO_W = 1 + 1 + ADDR_W + LANES + WORD_W;
    localparam int FIFO_DEPTH = 8;
    // Values after reset
    localparam logic [ADDR_W-1:0] ADDR_RST = 17'h0_0000;
    localparam logic [WORD_W-1:0] WORD_RST = 36'h0_0000_0000;
    localparam logic [LANES-1:0] LANES_OFF = 4'hf;
    localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
    localparam logic STRAP_RST = 1'b1;

    typedef enum logic [1:0] {
        SFB_IDLE = 2'b00,
        SFB_READ = 2'b01,
        SFB_WRITE = 2'b10
    } sfb_op_t;

    // Take new lanes where the active-low select is low; parity bit i rides with lane i
    function automatic logic [WORD_W-1:0] sfb_merge(
        input logic [WORD_W-1:0] old_w,
        input logic [WORD_W-1:0] new_w,
        input logic [LANES-1:0] sel_n
    );
        logic [WORD_W-1:0] r;
        r = old_w;
        for (int i = 0; i < LANES; i++) begin
            if (!sel_n[i]) begin
                r[LANE_W*i +: LANE_W] = new_w[LANE_W*i +: LANE_W];
                r[DQ_W + i] = new_w[DQ_W + i];
            end
        end
        return r;
    endfunction
endpackage
`default_nettype wire

// file: inc/sfb_if.sv
`timescale 1ns/1ns
`default_nettype none
interface sfb_if (
    input wire logic core_clk
);
    logic [16:0] addr;
    logic chip_sel_one_n;
    logic chip_sel_two;
    logic chip_sel_three_n;
    logic write_strobe_n;
    logic [3:0] byte_lane_write_sel;
    logic advance_or_load;
    logic clock_gate_n;
    logic output_drive_en_n;
    logic burst_mode_strap;
    logic [31:0] host_dq;
    logic [3:0] host_par;
    logic host_drive;
    logic [31:0] dev_dq;
    logic [3:0] dev_par;
    logic dev_drive;
    logic dev_on;
    logic [31:0] dq;
    logic [3:0] parity_lines;

    // Output enable acts without the clock on the device's drivers
    assign dev_on = dev_drive & ~output_drive_en_n;
    // Wire level of the shared data pins; an undriven bus reads as zero
    assign dq = dev_on ? dev_dq : (host_drive ? host_dq : '0);
    assign parity_lines = dev_on ? dev_par : (host_drive ? host_par : '0);

    modport dev (
        input addr, chip_sel_one_n, chip_sel_two, chip_sel_three_n, write_strobe_n,
        input byte_lane_write_sel, advance_or_load, clock_gate_n, burst_mode_strap,
        input dq, parity_lines,
        output dev_dq, dev_par, dev_drive
    );
    modport host (
        output addr, chip_sel_one_n, chip_sel_two, chip_sel_three_n, write_strobe_n,
        output byte_lane_write_sel, advance_or_load, clock_gate_n, burst_mode_strap,
        output output_drive_en_n, host_dq, host_par, host_drive,
        input dq, parity_lines
    );
endinterface
`default_nettype wire

// file: hdl/sfb_device.sv
`timescale 1ns/1ns
`default_nettype none
// Contract
// - All synchronous inputs registered on rising edge
// - Gate high ignores edges, stretches cycle
// - Write needs strobe low and lane select
// - Each select gates one byte plus parity
// - Writes complete internally, self-timed
// - Drivers off during write data phase
// - Seventeen-bit address sampled on edge
// - Write strobe sampled only with gate low
// - Master drives strobe low to write
// - Advance high steps the burst counter
// - Advance low loads a new address
// - Master loads fresh address after deselect
// - Back-to-back reads and writes, no waits
// - Three chip selects; async output enable
// - Static strap picks interleaved or linear
// - Read data from previous edge's address
// - Outputs off after a deselect load; an advance while deselected keeps them on
// - Select is one low, two high, three low
module sfb_device
    import sfb_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    sfb_if.dev bus,
    output sfb_op_t op_state,
    output logic [BURST_W-1:0] burst_pos,
    output logic interleave
);
    logic [WORD_W-1:0] mem [0:MEM_WORDS-1];

    logic mode_taken;
    logic [ADDR_W-1:0] base;
    logic wr_pend;
    logic [ADDR_W-1:0] wr_addr;
    logic [LANES-1:0] wr_lanes_n;
    logic [WORD_W-1:0] rd_word;
    logic drive;

    // Step function of the burst counter
    function automatic logic [BURST_W-1:0] sfb_burst(
        input logic [BURST_W-1:0] start,
        input logic [BURST_W-1:0] count,
        input logic ilv
    );
        return ilv ? (start ^ count) : BURST_W'(start + count);
    endfunction

    // Edge qualification and selection decode
    wire logic clk_en;
    wire logic sel_now;
    wire logic load_now;
    assign clk_en = ~bus.clock_gate_n;
    assign sel_now = ~bus.chip_sel_one_n & bus.chip_sel_two & ~bus.chip_sel_three_n;
    assign load_now = ~bus.advance_or_load;

    // Next access: a load starts fresh, an advance keeps op and base
    wire sfb_op_t next_op;
    wire logic [ADDR_W-1:0] next_base;
    wire logic [BURST_W-1:0] next_cnt;
    wire logic [ADDR_W-1:0] next_addr;
    assign next_op = !load_now ? op_state :
                     !sel_now ? SFB_IDLE :
                     bus.write_strobe_n ? SFB_READ : SFB_WRITE;
    assign next_base = load_now ? bus.addr : base;
    assign next_cnt = load_now ? BURST_RST : BURST_W'(burst_pos + 1'b1);
    // Upper bits always come from the loaded base
    assign next_addr = {next_base[ADDR_W-1:BURST_W],
                        sfb_burst(next_base[BURST_W-1:0], next_cnt, interleave)};

    // Incoming data word, parity in the top four bits
    wire logic [WORD_W-1:0] in_word;
    wire logic [WORD_W-1:0] mem_q;
    wire logic wr_hit;
    wire logic [WORD_W-1:0] fwd_word;
    assign in_word = {bus.parity_lines, bus.dq};
    assign mem_q = mem[next_addr];
    // Read right after a write to the same word sees the new lanes
    assign wr_hit = wr_pend && (wr_addr == next_addr);
    assign fwd_word = wr_hit ? sfb_merge(mem_q, in_word, wr_lanes_n) : mem_q;

    // Strap caught once after reset release; must stay static afterwards
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mode_taken <= 1'b0;
            interleave <= STRAP_RST;
        end else if (!mode_taken) begin
            mode_taken <= 1'b1;
            interleave <= bus.burst_mode_strap;
        end
    end

    // Input and control registers; all frozen while the gate is high
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            op_state <= SFB_IDLE;
            base <= ADDR_RST;
            burst_pos <= BURST_RST;
        end else if (clk_en) begin
            op_state <= next_op;
            base <= next_base;
            burst_pos <= next_cnt;
        end
    end

    // Write address phase; data follows one enabled edge later
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wr_pend <= 1'b0;
            wr_addr <= ADDR_RST;
            wr_lanes_n <= LANES_OFF;
        end else if (clk_en) begin
            wr_pend <= (next_op == SFB_WRITE);
            wr_addr <= next_addr;
            wr_lanes_n <= bus.byte_lane_write_sel;
        end
    end

    // Self-timed array write on the data edge; no extra pulse needed
    always_ff @(posedge core_clk) begin
        if (clk_en && wr_pend) begin
            mem[wr_addr] <= sfb_merge(mem[wr_addr], in_word, wr_lanes_n);
        end
    end

    // Flow-through read register and driver control
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rd_word <= WORD_RST;
            drive <= 1'b0;
        end else if (clk_en) begin
            rd_word <= fwd_word;
            // Off on writes and deselect loads, so no contention on the data pins
            drive <= (next_op == SFB_READ);
        end
    end

    assign bus.dev_dq = rd_word[DQ_W-1:0];
    assign bus.dev_par = rd_word[WORD_W-1:DQ_W];
    assign bus.dev_drive = drive;
endmodule
`default_nettype wire

// file: hdl/sfb_host.sv
`timescale 1ns/1ns
`default_nettype none
// Command buffer between user and pin sequencer
module sfb_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] store [0:DEPTH-1];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] count;

    wire logic push;
    wire logic pop;
    wire logic [PW:0] next_count;
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign next_count = (PW+1)'(count + push - pop);
    assign out_data = store[rd_ptr];

    // Flags kept as flops so ready and valid leave straight from registers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            wr_ptr <= push ? PW'(wr_ptr + 1'b1) : wr_ptr;
            rd_ptr <= pop ? PW'(rd_ptr + 1'b1) : rd_ptr;
            count <= next_count;
            in_ready <= (next_count != (PW+1)'(DEPTH));
            out_valid <= (next_count != '0);
        end
    end

    always_ff @(posedge core_clk) begin
        if (push) begin
            store[wr_ptr] <= in_data;
        end
    end
endmodule

// Bus master end: one buffered command per enabled cycle
module sfb_host
    import sfb_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic req_advance,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [LANES-1:0] req_lanes_n,
    input wire logic [WORD_W-1:0] req_data,
    input wire logic suspend,
    input wire logic interleave_strap,
    output logic rd_valid,
    output logic [WORD_W-1:0] rd_data,
    sfb_if.host bus
);
    logic gate_n;
    logic [ADDR_W-1:0] addr;
    logic cs_n;
    logic we_n;
    logic [LANES-1:0] lanes_n;
    logic adv;
    logic oe_n;
    logic strap;
    sfb_op_t s1_op;
    logic [WORD_W-1:0] s1_data;
    logic s2_read;
    logic [WORD_W-1:0] wdata;
    logic wdrive;

    // Buffered command; back-pressure reaches the user while suspended
    wire logic f_valid;
    wire logic [FIFO_W-1:0] f_data;
    wire logic step;
    sfb_fifo #(
        .WIDTH(FIFO_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .rst(rst),
        .in_valid(req_valid),
        .in_ready(req_ready),
        .in_data({req_write, req_advance, req_addr, req_lanes_n, req_data}),
        .out_valid(f_valid),
        .out_ready(step),
        .out_data(f_data)
    );

    // The device only sees edges while our gate is low, so we step with it
    assign step = ~gate_n;
    wire logic c_write;
    wire logic c_adv;
    wire logic [ADDR_W-1:0] c_addr;
    wire logic [LANES-1:0] c_lanes_n;
    wire logic [WORD_W-1:0] c_data;
    wire sfb_op_t c_op;
    assign {c_write, c_adv, c_addr, c_lanes_n, c_data} = f_data;
    // An advance continues whatever the last load started
    assign c_op = c_adv ? s1_op : (c_write ? SFB_WRITE : SFB_READ);

    // Address and control phase
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            gate_n <= 1'b1;
            addr <= ADDR_RST;
            cs_n <= 1'b1;
            we_n <= 1'b1;
            lanes_n <= LANES_OFF;
            adv <= 1'b0;
            s1_op <= SFB_IDLE;
            s1_data <= WORD_RST;
        end else begin
            gate_n <= suspend;
            if (step && f_valid) begin
                addr <= c_addr;
                cs_n <= 1'b0;
                we_n <= ~c_write;
                lanes_n <= c_lanes_n;
                adv <= c_adv;
                s1_op <= c_op;
                s1_data <= c_data;
            end else if (step) begin
                // Idle: deselect with a load so the next access starts fresh
                cs_n <= 1'b1;
                adv <= 1'b0;
                s1_op <= SFB_IDLE;
            end
        end
    end

    // Data phase: drive write data, capture read data
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wdata <= WORD_RST;
            wdrive <= 1'b0;
            s2_read <= 1'b0;
            rd_valid <= 1'b0;
            rd_data <= WORD_RST;
            oe_n <= 1'b1;
        end else begin
            oe_n <= 1'b0;
            rd_valid <= step && s2_read;
            if (step) begin
                wdata <= s1_data;
                wdrive <= (s1_op == SFB_WRITE);
                s2_read <= (s1_op == SFB_READ);
                if (s2_read) begin
                    rd_data <= {bus.parity_lines, bus.dq};
                end
            end
        end
    end

    // Strap follows its input through reset too; the device latches it at the first edge after release
    always_ff @(posedge core_clk) begin
        strap <= interleave_strap;
    end

    assign bus.clock_gate_n = gate_n;
    assign bus.addr = addr;
    assign bus.chip_sel_one_n = cs_n;
    assign bus.chip_sel_two = ~cs_n;
    assign bus.chip_sel_three_n = cs_n;
    assign bus.write_strobe_n = we_n;
    assign bus.byte_lane_write_sel = lanes_n;
    assign bus.advance_or_load = adv;
    assign bus.output_drive_en_n = oe_n;
    assign bus.burst_mode_strap = strap;
    assign bus.host_dq = wdata[DQ_W-1:0];
    assign bus.host_par = wdata[WORD_W-1:DQ_W];
    assign bus.host_drive = wdrive;
endmodule
`default_nettype wire

// file: dv/sfb_sva.sv
`timescale 1ns/1ns
`default_nettype none
module sfb_sva (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clock_gate_n,
    input wire logic chip_sel_one_n,
    input wire logic chip_sel_two,
    input wire logic chip_sel_three_n,
    input wire logic write_strobe_n,
    input wire logic advance_or_load,
    input wire logic host_drive,
    input wire logic dev_drive,
    input wire logic dev_on,
    input wire logic [31:0] dev_dq
);
    wire sel;
    wire load_en;

    // Selection and load decode as the device sees it
    assign sel = !chip_sel_one_n && chip_sel_two && !chip_sel_three_n;
    assign load_en = !clock_gate_n && !advance_or_load;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    // Load steps that start a transfer
    sequence s_rd_load;
        load_en && sel && write_strobe_n;
    endsequence
    sequence s_wr_load;
        load_en && sel && !write_strobe_n;
    endsequence

    a_read_drives: assert property (s_rd_load |=> dev_drive)
        else $error("read load left pins undriven");
    a_write_quiet: assert property (s_wr_load |=> !dev_drive)
        else $error("device drove during write data");
    a_write_data_out: assert property (s_wr_load |=> host_drive)
        else $error("host gave no write data");
    a_deselect_quiet: assert property (load_en && !sel |=> !dev_drive)
        else $error("device drove while deselected");
    a_gate_freeze: assert property (clock_gate_n && dev_drive |=> dev_drive && $stable(dev_dq))
        else $error("read data moved while gated");
    a_adv_keeps_read: assert property (!clock_gate_n && advance_or_load && dev_drive |=> dev_drive)
        else $error("advance dropped read burst");
    a_adv_stays_quiet: assert property (!clock_gate_n && advance_or_load && !dev_drive |=> !dev_drive)
        else $error("advance started a read");
    a_no_contention: assert property (host_drive |-> !dev_on)
        else $error("both ends drive the data pins");
    a_write_read_turn: assert property (s_wr_load ##1 s_rd_load |=> dev_drive && !host_drive)
        else $error("no clean turnaround after write");
endmodule
`default_nettype wire

// file: dv/sfb_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module sync_flowthrough_burst_sram_port_tb_top;
    import sfb_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic req_advance = 1'b0;
    logic [ADDR_W-1:0] req_addr = ADDR_RST;
    logic [LANES-1:0] req_lanes_n = LANES_OFF;
    logic [WORD_W-1:0] req_data = WORD_RST;
    logic suspend = 1'b0;
    logic interleave_strap = STRAP_RST;
    logic req_ready;
    logic rd_valid;
    logic [WORD_W-1:0] rd_data;
    logic interleave;
    int num_errors = 0;
    int samples_checked = 0;
    logic [WORD_W-1:0] exp_q[$];

    sfb_if u_sfb_if (.core_clk(core_clk));
    sfb_host u_sfb_host (.core_clk(core_clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
        .req_write(req_write), .req_advance(req_advance), .req_addr(req_addr), .req_lanes_n(req_lanes_n),
        .req_data(req_data), .suspend(suspend), .interleave_strap(interleave_strap), .rd_valid(rd_valid),
        .rd_data(rd_data), .bus(u_sfb_if.host));
    sfb_device u_sfb_device (.core_clk(core_clk), .rst(rst), .bus(u_sfb_if.dev), .op_state(),
        .burst_pos(), .interleave(interleave));
    sfb_sva u_sfb_sva (.core_clk(core_clk), .rst(rst), .clock_gate_n(u_sfb_if.clock_gate_n),
        .chip_sel_one_n(u_sfb_if.chip_sel_one_n), .chip_sel_two(u_sfb_if.chip_sel_two),
        .chip_sel_three_n(u_sfb_if.chip_sel_three_n), .write_strobe_n(u_sfb_if.write_strobe_n),
        .advance_or_load(u_sfb_if.advance_or_load), .host_drive(u_sfb_if.host_drive),
        .dev_drive(u_sfb_if.dev_drive), .dev_on(u_sfb_if.dev_on), .dev_dq(u_sfb_if.dev_dq));

    // Free-running 50 MHz clock
    always #10 core_clk = ~core_clk;

    task automatic check(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] expd);
        samples_checked++;
        if (seen !== expd) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, expd);
        end
    endtask

    task automatic stop_test;
        $display("Checks %0d, errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Valid stays up between pushes so back-to-back requests never glitch it
    task automatic push(input logic wr, input logic adv, input logic [ADDR_W-1:0] a,
        input logic [LANES-1:0] ln, input logic [WORD_W-1:0] d);
        req_valid <= 1'b1;
        req_write <= wr;
        req_advance <= adv;
        req_addr <= a;
        req_lanes_n <= ln;
        req_data <= d;
        do @(posedge core_clk); while (req_ready !== 1'b1);
    endtask

    task automatic rd(input logic adv, input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] e);
        exp_q.push_back(e);
        push(1'b0, adv, a, LANES_OFF, WORD_RST);
    endtask

    task automatic drain;
        int n;
        n = 0;
        req_valid <= 1'b0;
        @(posedge core_clk);
        while (exp_q.size() != 0 && n < 100) begin
            @(posedge core_clk);
            n++;
        end
        check(36'(n >= 100), WORD_RST);
    endtask

    function automatic logic [WORD_W-1:0] lane_mask(input int i);
        return (36'h0_0000_00ff << (LANE_W * i)) | (36'h1_0000_0000 << i);
    endfunction

    // Fill four words, then read them as one burst from the second word
    task automatic burst_run(input logic strap);
        logic [ADDR_W-1:0] b;
        logic [BURST_W-1:0] p;
        b = 17'h0_0200;
        interleave_strap <= strap;
        rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        check({35'h0, interleave}, {35'h0, strap});
        for (int k = 0; k < 4; k++) push(1'b1, 1'b0, b + 17'(k), 4'h0, 36'h9_1234_0000 + 36'(k));
        rd(1'b0, b + 17'h0_0001, 36'h9_1234_0001);
        for (int n = 1; n < 4; n++) begin
            p = strap ? (2'h1 ^ 2'(n)) : (2'h1 + 2'(n));
            rd(1'b1, b, 36'h9_1234_0000 + 36'(p));
        end
        drain;
    endtask

    // Read data in request order; an unasked read is a mismatch
    always @(posedge core_clk) begin
        if (rd_valid === 1'b1) begin
            if (exp_q.size() == 0) check(WORD_RST, 36'h0_0000_0001);
            else check(rd_data, exp_q.pop_front());
        end
    end

    // Watchdog well beyond the hundred or so cycles the tests need
    initial begin
        #200000;
        num_errors++;
        $display("Error at %0t: watchdog expired", $time);
        stop_test;
    end

    initial begin
        logic [WORD_W-1:0] w;
        w = 36'h5_a5a5_a5a5;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        // Full write, read straight after it, then one lane at a time
        push(1'b1, 1'b0, 17'h1_0100, 4'h0, w);
        rd(1'b0, 17'h1_0100, w);
        for (int i = 0; i < LANES; i++) begin
            push(1'b1, 1'b0, 17'h1_0100, ~(4'h1 << i), ~w);
            w = w ^ lane_mask(i);
            rd(1'b0, 17'h1_0100, w);
        end
        drain;
        burst_run(1'b1);
        burst_run(1'b0);
        // Suspended drain: FIFO fills, then reads freeze mid-flight
        suspend <= 1'b1;
        @(posedge core_clk);
        for (int k = 0; k < FIFO_DEPTH; k++) rd(1'b0, 17'h0_0200 + 17'(k % 4), 36'h9_1234_0000 + 36'(k % 4));
        req_valid <= 1'b0;
        @(posedge core_clk);
        check({35'h0, req_ready}, WORD_RST);
        suspend <= 1'b0;
        repeat (3) @(posedge core_clk);
        suspend <= 1'b1;
        repeat (4) @(posedge core_clk);
        suspend <= 1'b0;
        drain;
        stop_test;
    end
endmodule
`default_nettype wire
